//--- hdl/adc_pkg.sv
package adc_pkg;
    localparam int ADC_CHANNELS = 8;
    localparam int ADC_SUM_INPUTS = 4;
    localparam int ADC_SAMPLE_W = 24;
    localparam int ADC_VOL_W = 8;
    localparam int ADC_BIQUAD_MAX = 3;

    localparam logic [7:0] ADC_PAGE_DSP = 8'h00;
    localparam logic [7:0] ADC_OFF_DSP_CFG_A = 8'h6b;
    localparam logic [7:0] ADC_OFF_DSP_CFG_B = 8'h6c;
    localparam logic [7:0] ADC_OFF_ENHANCER = 8'h6d;
    localparam logic [7:0] ADC_OFF_GAIN_CTRL = 8'h70;
    localparam logic [7:0] ADC_OFF_CH_ENABLE = 8'h73;

    localparam logic [7:0] ADC_RST_DSP_CFG_A = 8'h01;
    localparam logic [7:0] ADC_RST_DSP_CFG_B = 8'h40;
    localparam logic [7:0] ADC_RST_ENHANCER = 8'h7b;
    localparam logic [7:0] ADC_RST_GAIN_CTRL = 8'he7;
    localparam logic [7:0] ADC_RST_CH_ENABLE = 8'hf0;
    localparam logic [7:0] ADC_MASK_DSP_CFG_A = 8'h3f;

    // Field positions: dsp_chain_config_a.
    localparam int ADC_DECIM_LSB = 4;
    localparam int ADC_SUM_LSB = 2;
    localparam int ADC_HPF_LSB = 0;
    // Field positions: dsp_chain_config_b.
    localparam int ADC_GANG_BIT = 7;
    localparam int ADC_BIQ_LSB = 5;
    localparam int ADC_SOFT_OFF_BIT = 4;
    localparam int ADC_DYN_SEL_BIT = 3;
    // Field positions: both dynamics registers.
    localparam int ADC_LEVEL_LSB = 4;
    localparam int ADC_LIMIT_LSB = 0;

    localparam logic [1:0] ADC_DECIM_RESERVED = 2'h3;
    localparam logic [1:0] ADC_HPF_CUSTOM = 2'h0;
    localparam logic [3:0] ADC_ENH_LEVEL_MAX = 4'h9;
    localparam logic [3:0] ADC_ENH_LIMIT_MAX = 4'hc;
    localparam logic [3:0] ADC_AGC_LIMIT_MAX = 4'hd;

    // Decibel maps: base value and step per code.
    localparam logic signed [7:0] ADC_ENH_LEVEL_BASE = -8'sd12;
    localparam logic [7:0] ADC_ENH_LEVEL_STEP = 8'h06;
    localparam logic [7:0] ADC_ENH_LIMIT_BASE = 8'h02;
    localparam logic [7:0] ADC_ENH_LIMIT_STEP = 8'h02;
    localparam logic signed [7:0] ADC_AGC_LEVEL_BASE = -8'sd6;
    localparam logic [7:0] ADC_AGC_LEVEL_STEP = 8'h02;
    localparam logic [7:0] ADC_AGC_LIMIT_BASE = 8'h03;
    localparam logic [7:0] ADC_AGC_LIMIT_STEP = 8'h03;

    typedef enum logic [1:0] {
        ADC_SUM_OFF,
        ADC_SUM_PAIRS,
        ADC_SUM_QUAD,
        ADC_SUM_RESERVED
    } adc_sum_mode_t;
endpackage

//--- hdl/adc_cfg_if.sv
`timescale 1ns/100ps
interface adc_cfg_if;
    import adc_pkg::*;
    logic volume_gang;
    logic [1:0] biquad_count;
    logic [ADC_CHANNELS-1:0] channel_on;
    adc_sum_mode_t summation_mode;
    modport regs (output volume_gang, output biquad_count, output channel_on, output summation_mode);
    modport user (input volume_gang, input biquad_count, input channel_on, input summation_mode);
endinterface // adc_cfg_if

//--- hdl/adc_chan_plan.sv
`timescale 1ns/100ps
module adc_chan_plan
    import adc_pkg::*;
(
    adc_cfg_if.user cfg,
    input wire logic [ADC_CHANNELS*ADC_VOL_W-1:0] chan_volume,
    output logic [ADC_CHANNELS*ADC_VOL_W-1:0] volume_used,
    output logic [ADC_CHANNELS*ADC_BIQUAD_MAX-1:0] biquad_on
);
    genvar ch;
    generate
        for (ch = 0; ch < ADC_CHANNELS; ch = ch + 1) begin : g_ch
            // Channel one sits in the lowest lane; gang copies it even when channel one is off.
            assign volume_used[ch*ADC_VOL_W +: ADC_VOL_W] = !cfg.channel_on[ADC_CHANNELS-1-ch] ? '0 :
                cfg.volume_gang ? chan_volume[0 +: ADC_VOL_W] : chan_volume[ch*ADC_VOL_W +: ADC_VOL_W]; // [RL6] [RL7]
            assign biquad_on[ch*ADC_BIQUAD_MAX + 0] = cfg.biquad_count >= 2'h1; // [RL8] [RL9]
            assign biquad_on[ch*ADC_BIQUAD_MAX + 1] = cfg.biquad_count >= 2'h2; // [RL8]
            assign biquad_on[ch*ADC_BIQUAD_MAX + 2] = cfg.biquad_count == 2'h3; // [RL8]
        end
    endgenerate
endmodule // adc_chan_plan

//--- hdl/adc_chan_sum.sv
`timescale 1ns/100ps
module adc_chan_sum
    import adc_pkg::*;
(
    adc_cfg_if.user cfg,
    input wire logic [ADC_SUM_INPUTS*ADC_SAMPLE_W-1:0] samples,
    output logic [ADC_SUM_INPUTS*ADC_SAMPLE_W-1:0] summed
);
    localparam int SW = ADC_SAMPLE_W + 2;
    logic signed [SW-1:0] s1, s2, s3, s4, pair_a, pair_b, quad;

    // Sums are widened by two bits so that averaging never overflows.
    assign s1 = SW'($signed(samples[0*ADC_SAMPLE_W +: ADC_SAMPLE_W]));
    assign s2 = SW'($signed(samples[1*ADC_SAMPLE_W +: ADC_SAMPLE_W]));
    assign s3 = SW'($signed(samples[2*ADC_SAMPLE_W +: ADC_SAMPLE_W]));
    assign s4 = SW'($signed(samples[3*ADC_SAMPLE_W +: ADC_SAMPLE_W]));
    assign pair_a = (s1 + s2) >>> 1; // [RL2]
    assign pair_b = (s3 + s4) >>> 1; // [RL2]
    assign quad = (s1 + s2 + s3 + s4) >>> 2; // [RL3]

    always_comb begin
        summed = samples;
        unique case (cfg.summation_mode)
            ADC_SUM_PAIRS: begin
                summed = {{(2*ADC_SAMPLE_W){1'b0}}, pair_b[ADC_SAMPLE_W-1:0], pair_a[ADC_SAMPLE_W-1:0]}; // [RL2]
            end
            ADC_SUM_QUAD: begin
                summed = {{(3*ADC_SAMPLE_W){1'b0}}, quad[ADC_SAMPLE_W-1:0]}; // [RL3]
            end
            ADC_SUM_OFF, ADC_SUM_RESERVED: begin
                summed = samples; // [RL3]
            end
        endcase
    end
endmodule // adc_chan_sum

//--- hdl/adc_dsp_chain_config.sv
// Function
// [RL1] Decimation response code at bits 5-4: linear, low, ultra-low latency; 3 reserved.
// [RL2] Summation code 1 averages channels one+two and three+four separately.
// [RL3] Summation code 2 averages channels one to four; 0 off, 3 reserved.
// [RL4] Highpass code 0 selects programmable first-order IIR, defaults all-pass.
// [RL5] Highpass codes 1-3 pick fixed cutoffs 0.00025, 0.002, 0.008 fs; reset 1.
// [RL6] Gang bit 7 clear: each channel uses its own volume.
// [RL7] Gang bit set: every active channel uses channel one volume.
// [RL8] Biquad count at bits 6-5 enables 0 to 3 biquads; reset 2.
// [RL9] Biquad count 0 bypasses every biquad on every channel.
// [RL10] Bit 4 clear soft-steps volume, mute, unmute; set applies them directly.
// [RL11] Bit 3 picks range enhancer when 0, gain controller when 1.
// [RL12] Enhancer threshold codes 0-9 map -12 to -66 dB by 6; reset 7.
// [RL13] Enhancer threshold codes 10-15 are reserved.
// [RL14] Enhancer gain limit codes 0-12 map 2 to 26 dB by 2; reset 11.
// [RL15] Gain controller target codes 0-15 map -6 to -36 dB by 2; reset 14.
// [RL16] Gain controller limit codes 0-13 map 3 to 42 dB by 3; reset 7.
// [RL17] Channel enable register: channel one bit 7 to eight bit 0; reset 0xf0.
// [RL18] Enable bit 0 disables, 1 enables; channels five to eight are microphone only.
// [RL19] Decimation, summation, highpass register lives at 0x6b on page 0.
`timescale 1ns/100ps
module adc_dsp_chain_config
    import adc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] page_sel,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    input wire logic [ADC_CHANNELS*ADC_VOL_W-1:0] chan_volume,
    input wire logic [ADC_SUM_INPUTS*ADC_SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid,
    output logic [ADC_SUM_INPUTS*ADC_SAMPLE_W-1:0] sample_out,
    output logic sample_out_valid,
    output logic [1:0] decimation_response_sel,
    output logic decimation_reserved,
    output logic [1:0] highpass_choice,
    output logic custom_iir_on,
    output logic [ADC_CHANNELS*ADC_VOL_W-1:0] volume_used,
    output logic [ADC_CHANNELS*ADC_BIQUAD_MAX-1:0] biquad_on,
    output logic soft_step_on,
    output logic enhancer_on,
    output logic gain_ctrl_on,
    output logic signed [7:0] enhancer_threshold_db,
    output logic [7:0] enhancer_gain_limit_db,
    output logic signed [7:0] gain_ctrl_target_db,
    output logic [7:0] gain_ctrl_limit_db,
    output logic dynamics_code_reserved,
    output logic [ADC_CHANNELS-1:0] channel_on
);
    logic [7:0] cfg_a_q;
    logic [7:0] cfg_b_q;
    logic [7:0] enh_q;
    logic [7:0] agc_q;
    logic [7:0] chen_q;
    logic on_page;
    logic [7:0] rdata_d;
    logic [3:0] enh_level, enh_limit, agc_level, agc_limit;
    logic [ADC_CHANNELS*ADC_VOL_W-1:0] volume_plan;
    logic [ADC_CHANNELS*ADC_BIQUAD_MAX-1:0] biquad_plan;
    logic [ADC_SUM_INPUTS*ADC_SAMPLE_W-1:0] summed;

    adc_cfg_if cfg ();

    assign on_page = page_sel == ADC_PAGE_DSP; // [RL19]
    assign enh_level = enh_q[ADC_LEVEL_LSB +: 4];
    assign enh_limit = enh_q[ADC_LIMIT_LSB +: 4];
    assign agc_level = agc_q[ADC_LEVEL_LSB +: 4];
    assign agc_limit = agc_q[ADC_LIMIT_LSB +: 4];

    assign cfg.volume_gang = cfg_b_q[ADC_GANG_BIT];
    assign cfg.biquad_count = cfg_b_q[ADC_BIQ_LSB +: 2];
    assign cfg.channel_on = chen_q;
    assign cfg.summation_mode = adc_sum_mode_t'(cfg_a_q[ADC_SUM_LSB +: 2]);

    // Reserved codes are stored as written; decimation and dynamics outputs flag them, while summation code 3 passes samples unchanged unflagged.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_a_q <= ADC_RST_DSP_CFG_A; // [RL5]
        end else if (reg_wr && on_page && reg_addr == ADC_OFF_DSP_CFG_A) begin
            cfg_a_q <= reg_wdata & ADC_MASK_DSP_CFG_A; // [RL19]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_b_q <= ADC_RST_DSP_CFG_B; // [RL8]
        end else if (reg_wr && on_page && reg_addr == ADC_OFF_DSP_CFG_B) begin
            cfg_b_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enh_q <= ADC_RST_ENHANCER; // [RL12] [RL14]
        end else if (reg_wr && on_page && reg_addr == ADC_OFF_ENHANCER) begin
            enh_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            agc_q <= ADC_RST_GAIN_CTRL; // [RL15] [RL16]
        end else if (reg_wr && on_page && reg_addr == ADC_OFF_GAIN_CTRL) begin
            agc_q <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            chen_q <= ADC_RST_CH_ENABLE; // [RL17]
        end else if (reg_wr && on_page && reg_addr == ADC_OFF_CH_ENABLE) begin
            chen_q <= reg_wdata; // [RL18]
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (on_page) begin
            unique case (reg_addr)
                ADC_OFF_DSP_CFG_A: rdata_d = cfg_a_q & ADC_MASK_DSP_CFG_A;
                ADC_OFF_DSP_CFG_B: rdata_d = cfg_b_q;
                ADC_OFF_ENHANCER: rdata_d = enh_q;
                ADC_OFF_GAIN_CTRL: rdata_d = agc_q;
                ADC_OFF_CH_ENABLE: rdata_d = chen_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_wr | reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            decimation_response_sel <= 2'h0;
            decimation_reserved <= 1'b0;
            highpass_choice <= 2'h0;
            custom_iir_on <= 1'b0;
        end else begin
            decimation_response_sel <= cfg_a_q[ADC_DECIM_LSB +: 2]; // [RL1]
            decimation_reserved <= cfg_a_q[ADC_DECIM_LSB +: 2] == ADC_DECIM_RESERVED; // [RL1]
            highpass_choice <= cfg_a_q[ADC_HPF_LSB +: 2]; // [RL5]
            custom_iir_on <= cfg_a_q[ADC_HPF_LSB +: 2] == ADC_HPF_CUSTOM; // [RL4]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            soft_step_on <= 1'b1;
            enhancer_on <= 1'b0;
            gain_ctrl_on <= 1'b0;
        end else begin
            soft_step_on <= !cfg_b_q[ADC_SOFT_OFF_BIT]; // [RL10]
            enhancer_on <= !cfg_b_q[ADC_DYN_SEL_BIT]; // [RL11]
            gain_ctrl_on <= cfg_b_q[ADC_DYN_SEL_BIT]; // [RL11]
        end
    end

    // Step products stay well inside eight bits for the legal codes; reserved codes also fit without wrapping and are flagged.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enhancer_threshold_db <= 8'sh00;
            enhancer_gain_limit_db <= 8'h00;
            gain_ctrl_target_db <= 8'sh00;
            gain_ctrl_limit_db <= 8'h00;
            dynamics_code_reserved <= 1'b0;
        end else begin
            enhancer_threshold_db <= 8'(ADC_ENH_LEVEL_BASE - $signed(8'({4'h0, enh_level} * ADC_ENH_LEVEL_STEP))); // [RL12]
            enhancer_gain_limit_db <= 8'(ADC_ENH_LIMIT_BASE + 8'({4'h0, enh_limit} * ADC_ENH_LIMIT_STEP)); // [RL14]
            gain_ctrl_target_db <= 8'(ADC_AGC_LEVEL_BASE - $signed(8'({4'h0, agc_level} * ADC_AGC_LEVEL_STEP))); // [RL15]
            gain_ctrl_limit_db <= 8'(ADC_AGC_LIMIT_BASE + 8'({4'h0, agc_limit} * ADC_AGC_LIMIT_STEP)); // [RL16]
            dynamics_code_reserved <= (enh_level > ADC_ENH_LEVEL_MAX) || (enh_limit > ADC_ENH_LIMIT_MAX)
                || (agc_limit > ADC_AGC_LIMIT_MAX); // [RL13] [RL14] [RL16]
        end
    end

    adc_chan_plan u_plan (
        .cfg(cfg.user),
        .chan_volume(chan_volume),
        .volume_used(volume_plan),
        .biquad_on(biquad_plan)
    );

    adc_chan_sum u_sum (
        .cfg(cfg.user),
        .samples(sample_in),
        .summed(summed)
    );

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            volume_used <= '0;
            biquad_on <= '0;
            channel_on <= '0;
        end else begin
            volume_used <= volume_plan; // [RL6] [RL7]
            biquad_on <= biquad_plan; // [RL8] [RL9]
            channel_on <= chen_q; // [RL17] [RL18]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sample_out <= '0;
            sample_out_valid <= 1'b0;
        end else begin
            sample_out_valid <= sample_valid;
            if (sample_valid) begin
                sample_out <= summed; // [RL2] [RL3]
            end
        end
    end
endmodule // adc_dsp_chain_config

//--- sim/adc_dsp_chain_config_asserts.sv
`timescale 1ns/100ps
module adc_dsp_chain_config_asserts
    import adc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] page_sel,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic sample_valid,
    input wire logic sample_out_valid,
    input wire logic [1:0] decimation_response_sel,
    input wire logic decimation_reserved,
    input wire logic [1:0] highpass_choice,
    input wire logic custom_iir_on,
    input wire logic [ADC_CHANNELS*ADC_BIQUAD_MAX-1:0] biquad_on,
    input wire logic soft_step_on,
    input wire logic enhancer_on,
    input wire logic gain_ctrl_on,
    input wire logic [ADC_CHANNELS-1:0] channel_on
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic wr_b;
    logic wr_en;
    assign wr_b = reg_wr && page_sel == 8'h00 && reg_addr == ADC_OFF_DSP_CFG_B;
    assign wr_en = reg_wr && page_sel == 8'h00 && reg_addr == ADC_OFF_CH_ENABLE;
    AST_ACK: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("ack missing");
    AST_NO_ACK: assert property (!(reg_wr || reg_rd) |=> !reg_ack) else $error("stray ack");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    AST_SOFT: assert property (wr_b |-> ##2 soft_step_on != $past(reg_wdata[4], 2)) else $error("soft step");
    AST_CH_EN: assert property (wr_en |-> ##2 channel_on == $past(reg_wdata, 2)) else $error("enables");
    AST_DYN: assert property (!$past(reset) |-> enhancer_on ^ gain_ctrl_on) else $error("dynamics choice");
    AST_IIR: assert property (!$past(reset) |-> custom_iir_on == (highpass_choice == 2'h0)) else $error("iir");
    AST_DECIM: assert property (!$past(reset) |-> decimation_reserved == (decimation_response_sel == 2'h3))
        else $error("decimation reserved flag");
    AST_BIQ: assert property (!$past(reset) |-> biquad_on[2:0] inside {3'h0, 3'h1, 3'h3, 3'h7}) else $error("biq");
    AST_SAMPLE: assert property (sample_valid |=> sample_out_valid) else $error("sample valid lost");
    cover property (wr_b);
    cover property (reg_rd && page_sel != 8'h00);
    cover property (sample_valid [*3]);
endmodule // adc_dsp_chain_config_asserts
bind adc_dsp_chain_config adc_dsp_chain_config_asserts adc_dsp_chain_config_asserts_inst (.*);

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    import adc_pkg::*;
    logic ref_clk, reset, reg_wr, reg_rd, reg_ack, sample_valid, sample_out_valid, decimation_reserved;
    logic custom_iir_on, soft_step_on, enhancer_on, gain_ctrl_on, dynamics_code_reserved;
    logic [7:0] page_sel, reg_addr, reg_wdata, reg_rdata, channel_on, enhancer_gain_limit_db, gain_ctrl_limit_db;
    logic [1:0] decimation_response_sel, highpass_choice;
    logic signed [7:0] enhancer_threshold_db, gain_ctrl_target_db;
    logic [63:0] chan_volume, volume_used;
    logic [95:0] sample_in, sample_out, e;
    logic [23:0] biquad_on;
    logic [7:0] d, v;
    logic [7:0] regs [5] = '{8'h6b, 8'h6c, 8'h6d, 8'h70, 8'h73};
    logic [7:0] rstv [5] = '{8'h01, 8'h40, 8'h7b, 8'he7, 8'hf0};
    int bad_count, n_compared;
    adc_dsp_chain_config adc_dsp_chain_config_inst (.*);
    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One access; returns one edge after the ack so decoded outputs have landed.
    task automatic bus(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] wd, input logic w);
        page_sel = pg;
        reg_addr = a;
        reg_wdata = wd;
        reg_wr = w;
        reg_rd = !w;
        @(posedge ref_clk);
        #1;
        reg_wr = 0;
        reg_rd = 0;
        chk(reg_ack, 1, "ack");
        @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [23:0] biq(input logic [1:0] n);
        return {8{3'((4'h1 << n) - 4'h1)}};
    endfunction
    function automatic logic [95:0] sum_exp(input logic [1:0] m, input logic [95:0] s);
        logic signed [25:0] x [4];
        for (int i = 0; i < 4; i++) x[i] = signed'(s[i*24 +: 24]);
        if (m == 2'h1) return {48'h0, 24'((x[2] + x[3]) >>> 1), 24'((x[0] + x[1]) >>> 1)};
        if (m == 2'h2) return {72'h0, 24'((x[0] + x[1] + x[2] + x[3]) >>> 2)};
        return s;
    endfunction
    function automatic logic [63:0] vol_exp(input logic g, input logic [7:0] en, input logic [63:0] cv);
        logic [63:0] r;
        for (int i = 0; i < 8; i++) r[i*8 +: 8] = en[7-i] ? (g ? cv[7:0] : cv[i*8 +: 8]) : 8'h00;
        return r;
    endfunction
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #200us;
        bad_count++;
        final_report();
    end
    initial begin
        {reset, reg_wr, reg_rd, sample_valid, page_sel, reg_addr, reg_wdata} = 28'h8000000;
        chan_volume = 0;
        sample_in = 0;
        v = 8'($urandom(32'hef9dcae6));
        repeat (8) @(posedge ref_clk);
        #1 reset = 0;
        @(posedge ref_clk);
        #1;
        foreach (regs[i]) begin
            bus(0, regs[i], 0, 0);
            chk(reg_rdata, rstv[i], "reset value");
        end
        chk(highpass_choice, 1, "hpf reset");
        chk(biquad_on, biq(2), "biquad reset");
        bus(0, 8'h6e, 0, 0);
        chk(reg_rdata, 0, "unmapped");
        bus(1, 8'h6b, 0, 0);
        chk(reg_rdata, 0, "other page");
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            d = {2'h3, c[1:0], c[1:0], c[1:0]};
            bus(0, 8'h6b, d, 1);
            chk(decimation_response_sel, c, "decim");
            chk(decimation_reserved, c == 3, "decim reserved");
            chk(highpass_choice, c, "hpf");
            chk(custom_iir_on, c == 0, "iir");
            bus(0, 8'h6b, 0, 0);
            chk(reg_rdata, {2'h0, d[5:0]}, "cfg a read");
            sample_valid = 1;
            repeat (3) begin
                sample_in = {$urandom, $urandom, $urandom};
                e = sum_exp(c[1:0], sample_in);
                @(posedge ref_clk);
                #1;
                chk(sample_out_valid, 1, "out valid");
                chk(sample_out, e, "sum");
            end
            sample_valid = 0;
        end
        $display("test filter and summation done");
        for (int i = 0; i < 12; i++) begin
            d = (i < 4) ? {1'b0, i[1:0], 5'h10} : 8'($urandom);
            bus(0, 8'h6c, d, 1);
            chk(biquad_on, biq(d[6:5]), "biquad");
            chk(soft_step_on, !d[4], "soft step");
            chk({enhancer_on, gain_ctrl_on}, {!d[3], d[3]}, "dyn sel");
            bus(0, 8'h6c, 0, 0);
            chk(reg_rdata, d, "cfg b read");
        end
        $display("test cfg b done");
        for (int i = 0; i < 24; i++) begin
            d = (i < 16) ? {i[3:0], i[3:0]} : 8'($urandom);
            bus(0, 8'h6d, d, 1);
            bus(0, 8'h70, d, 1);
            if (d[7:4] < 4'ha) chk({enhancer_threshold_db}, 8'(-12 - 6 * d[7:4]), "enh lvl");
            if (d[3:0] < 4'hd) chk(enhancer_gain_limit_db, 8'(2 + 2 * d[3:0]), "enh gain");
            chk({gain_ctrl_target_db}, 8'(-6 - 2 * d[7:4]), "gain_ctrl_target");
            if (d[3:0] < 4'he) chk(gain_ctrl_limit_db, 8'(3 + 3 * d[3:0]), "agc gain");
            chk(dynamics_code_reserved, d[7:4] > 9 || d[3:0] > 12, "reserved");
        end
        $display("test dynamics done");
        for (int i = 0; i < 8; i++) begin
            chan_volume = {$urandom, $urandom};
            // First pass gangs with channel one switched off.
            v = (i == 0) ? 8'h7f : 8'($urandom);
            d = {~i[0], 2'h2, 5'h0};
            bus(0, 8'h73, v, 1);
            bus(1, 8'h73, ~v, 1);
            bus(0, 8'h6c, d, 1);
            chk(channel_on, v, "channel enables");
            chk(volume_used, vol_exp(d[7], v, chan_volume), "volume");
        end
        $display("test volume done");
        final_report();
    end
endmodule // testbench
